/* File: clr_responder.v */
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "clr_defs.vh"

// Summary of operation
// (RQ1) upper request half picks standard, extended or vendor-specific function set
// (RQ2) any unsupported function code returns zero in all four result words
// (RQ3) fixed-size strings are zero padded; no terminating null is promised
// (RQ4) vendor strings pack EBX-EDX-ECX; longer strings pack EAX-EBX-ECX-EDX
// (RQ5) standard maximum level reads 1, or 3 with serial function enabled
// (RQ6) standard vendor string comes from three programmable words with reset default
// (RQ7) signature word: type, family, model, stepping from programmable register
// (RQ8) standard function 1 returns zero in EBX and ECX
// (RQ9) standard feature flags default 0080813F, each bit maskable to zero
// (RQ10) serial function returns serial string in all four words
// (RQ11) extended maximum level 80000006 plus fixed vendor string
// (RQ12) extended function 1 returns fixed feature flags 0081893F
// (RQ13) extended functions 2-4 return 48-char name with programmable model part
// (RQ14) extended function 5 EBX holds TLB descriptor 04FF04FF
// (RQ15) extended function 5 ECX holds level-one data cache descriptor
// (RQ16) extended function 5 EDX holds level-one code cache descriptor
// (RQ17) extended function 6 ECX holds level-two descriptor chosen by variant
// (RQ18) accepted at any privilege; results wait until older instructions complete
// (RQ19) identification-support flag stays writable so software can toggle it
// (RQ20) vendor-specific maximum level returns 80860007
// (RQ21) function code captured on request; four results plus valid one clock after older work has retired
module clr_responder #(
  // arbitrary neutral defaults, not any maker's strings
  parameter [31:0] VEND_A_RESET = 32'h706D_6153,
  parameter [31:0] VEND_B_RESET = 32'h6556_656C,
  parameter [31:0] VEND_C_RESET = 32'h726F_646E,
  parameter [31:0] EXT_VEND_EBX = 32'h6E65_704F,
  parameter [31:0] EXT_VEND_EDX = 32'h6572_6F43,
  parameter [31:0] EXT_VEND_ECX = 32'h7469_6E55,
  // arbitrary signature values
  parameter [31:0] SIG_RESET = 32'h0000_0421,
  parameter [31:0] EXT_SIGNATURE = 32'h0000_0421,
  // arbitrary fixed name prefix, 16 characters
  parameter [127:0] NAME_PREFIX = 128'h2055_5043_2065_726F_4320_656C_706D_6153
)(
  // clock and reset
  input wire mclk,
  input wire reset,
  // register port
  input wire [5:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  // identification request
  input wire reqValid,
  input wire [31:0] reqFunction,
  input wire olderRetired,
  output wire reqBusy,
  // identification result
  output reg respValid,
  output reg [31:0] resultEax,
  output reg [31:0] resultEbx,
  output reg [31:0] resultEcx,
  output reg [31:0] resultEdx,
  // processor flags support bit
  output wire idFlag
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] funcHeld;
  reg [2:0] ctrl;
  reg [31:0] vendA;
  reg [31:0] vendB;
  reg [31:0] vendC;
  reg [31:0] signature;
  reg [31:0] featMask;
  reg [31:0] serial0;
  reg [31:0] serial1;
  reg [31:0] serial2;
  reg [31:0] serial3;
  reg [31:0] model0;
  reg [31:0] model1;
  reg [31:0] model2;
  reg [31:0] next_eax;
  reg [31:0] next_ebx;
  reg [31:0] next_ecx;
  reg [31:0] next_edx;
  reg [31:0] next_rdata;
  wire [31:0] lookupFunc;
  wire [15:0] funcSet;
  wire [15:0] funcLeaf;
  wire [383:0] nameString;
  wire serialEn;
  wire fire;

  assign serialEn = ctrl[`CLR_CTRL_SERIAL_EN];
  assign idFlag = ctrl[`CLR_CTRL_ID_FLAG];
  assign reqBusy = (state == ST_WAIT);

  // name: fixed prefix, 11 model characters, the rest zero fill
  assign nameString = {160'h0, 8'h00, model2[23:0], model1, model0, NAME_PREFIX}; // RQ13 RQ3

  function [31:0] nameWord;
    input [383:0] str;
    input [3:0] idx;
    begin
      nameWord = str[idx*32 +: 32];
    end
  endfunction

  // serialization: answer only once older work has drained
  assign fire = (state == ST_IDLE) ? (reqValid && olderRetired) : olderRetired; // RQ18
  assign lookupFunc = (state == ST_WAIT) ? funcHeld : reqFunction; // RQ21
  assign funcSet = lookupFunc[31:16];
  assign funcLeaf = lookupFunc[15:0];

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (reqValid && !olderRetired)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (olderRetired)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // result lookup; no privilege input, so every request is served
  always @*
  begin
    next_eax = `CLR_ZERO; // RQ2
    next_ebx = `CLR_ZERO;
    next_ecx = `CLR_ZERO;
    next_edx = `CLR_ZERO;
    case (funcSet) // RQ1
      `CLR_SET_STD:
      begin
        case (funcLeaf)
          `CLR_LEAF_0:
          begin
            next_eax = serialEn ? `CLR_STD_MAX_SERIAL : `CLR_STD_MAX_NOSERIAL; // RQ5
            next_ebx = vendA; // RQ6 RQ4
            next_edx = vendB;
            next_ecx = vendC;
          end
          `CLR_LEAF_1:
          begin
            next_eax = signature & `CLR_SIG_KEEP_MASK; // RQ7
            next_ebx = `CLR_ZERO; // RQ8
            next_ecx = `CLR_ZERO;
            next_edx = `CLR_STD_FEATURES & featMask; // RQ9
            // serial support reads absent while the serial function is off
            next_edx[`CLR_FEAT_SERIAL_BIT] = next_edx[`CLR_FEAT_SERIAL_BIT] & serialEn;
          end
          `CLR_LEAF_3:
          begin
            // disabled output is undefined; zero is the cheapest choice
            if (serialEn && (next_eax == `CLR_ZERO))
            begin
              next_eax = serial0; // RQ10 RQ4
              next_ebx = serial1;
              next_ecx = serial2;
              next_edx = serial3;
            end
          end
          default:
          begin
            next_eax = `CLR_ZERO; // RQ2
          end
        endcase
      end
      `CLR_SET_EXT:
      begin
        case (funcLeaf)
          `CLR_LEAF_0:
          begin
            next_eax = `CLR_EXT_MAX; // RQ11
            next_ebx = EXT_VEND_EBX; // RQ4
            next_edx = EXT_VEND_EDX;
            next_ecx = EXT_VEND_ECX;
          end
          `CLR_LEAF_1:
          begin
            next_eax = EXT_SIGNATURE;
            next_edx = `CLR_EXT_FEATURES; // RQ12
          end
          `CLR_LEAF_2, `CLR_LEAF_3, `CLR_LEAF_4:
          begin
            next_eax = nameWord(nameString, {funcLeaf[1:0] - 2'd2, 2'd0}); // RQ13 RQ4
            next_ebx = nameWord(nameString, {funcLeaf[1:0] - 2'd2, 2'd1});
            next_ecx = nameWord(nameString, {funcLeaf[1:0] - 2'd2, 2'd2});
            next_edx = nameWord(nameString, {funcLeaf[1:0] - 2'd2, 2'd3});
          end
          `CLR_LEAF_5:
          begin
            next_ebx = `CLR_TLB_DESC; // RQ14
            next_ecx = `CLR_L1D_DESC; // RQ15
            next_edx = `CLR_L1C_DESC; // RQ16
          end
          `CLR_LEAF_6:
          begin
            next_ecx = ctrl[`CLR_CTRL_L2_LARGE] ? `CLR_L2_DESC_LARGE : `CLR_L2_DESC_SMALL; // RQ17
          end
          default:
          begin
            next_eax = `CLR_ZERO; // RQ2
          end
        endcase
      end
      `CLR_SET_VND:
      begin
        // only the maximum-level leaf is served here; the others read zero
        if (funcLeaf == `CLR_LEAF_0)
        begin
          next_eax = `CLR_VND_MAX; // RQ20
          next_ebx = EXT_VEND_EBX; // RQ4
          next_edx = EXT_VEND_EDX;
          next_ecx = EXT_VEND_ECX;
        end
      end
      default:
      begin
        next_eax = `CLR_ZERO; // RQ2
      end
    endcase
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      funcHeld <= `CLR_ZERO;
      respValid <= 1'b0;
      resultEax <= `CLR_ZERO;
      resultEbx <= `CLR_ZERO;
      resultEcx <= `CLR_ZERO;
      resultEdx <= `CLR_ZERO;
    end
    else
    begin
      state <= next_state;
      // held code keeps a waiting answer immune to later changes on the request pins
      if (state == ST_IDLE && reqValid)
        funcHeld <= reqFunction; // RQ21
      respValid <= fire; // RQ21 RQ18
      if (fire)
      begin
        resultEax <= next_eax;
        resultEbx <= next_ebx;
        resultEcx <= next_ecx;
        resultEdx <= next_edx;
      end
    end
  end

  // register writes
  always @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl <= `CLR_RST_CTRL;
      vendA <= VEND_A_RESET; // RQ6
      vendB <= VEND_B_RESET;
      vendC <= VEND_C_RESET;
      signature <= SIG_RESET;
      featMask <= `CLR_RST_MASK;
      serial0 <= `CLR_ZERO;
      serial1 <= `CLR_ZERO;
      serial2 <= `CLR_ZERO;
      serial3 <= `CLR_ZERO;
      model0 <= `CLR_ZERO;
      model1 <= `CLR_ZERO;
      model2 <= `CLR_ZERO;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `CLR_OFS_CTRL: ctrl <= regWdata[2:0]; // RQ19
        `CLR_OFS_VEND_A: vendA <= regWdata; // RQ6
        `CLR_OFS_VEND_B: vendB <= regWdata;
        `CLR_OFS_VEND_C: vendC <= regWdata;
        `CLR_OFS_SIG: signature <= regWdata & `CLR_SIG_KEEP_MASK; // RQ7
        `CLR_OFS_MASK: featMask <= regWdata; // RQ9
        `CLR_OFS_SERIAL0: serial0 <= regWdata; // RQ10
        `CLR_OFS_SERIAL1: serial1 <= regWdata;
        `CLR_OFS_SERIAL2: serial2 <= regWdata;
        `CLR_OFS_SERIAL3: serial3 <= regWdata;
        `CLR_OFS_MODEL0: model0 <= regWdata; // RQ13
        `CLR_OFS_MODEL1: model1 <= regWdata;
        `CLR_OFS_MODEL2: model2 <= {8'h00, regWdata[23:0]};
        default:
        begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // register reads, data one cycle after the strobe only
  // zero between reads keeps a stale word from looking like a fresh answer
  always @*
  begin
    next_rdata = `CLR_ZERO;
    case (regAddr)
      `CLR_OFS_CTRL: next_rdata = {29'h0, ctrl}; // RQ19
      `CLR_OFS_VEND_A: next_rdata = vendA;
      `CLR_OFS_VEND_B: next_rdata = vendB;
      `CLR_OFS_VEND_C: next_rdata = vendC;
      `CLR_OFS_SIG: next_rdata = signature;
      `CLR_OFS_MASK: next_rdata = featMask;
      `CLR_OFS_SERIAL0: next_rdata = serial0;
      `CLR_OFS_SERIAL1: next_rdata = serial1;
      `CLR_OFS_SERIAL2: next_rdata = serial2;
      `CLR_OFS_SERIAL3: next_rdata = serial3;
      `CLR_OFS_MODEL0: next_rdata = model0;
      `CLR_OFS_MODEL1: next_rdata = model1;
      `CLR_OFS_MODEL2: next_rdata = model2;
      `CLR_OFS_STATUS: next_rdata = {30'h0, respValid, reqBusy};
      default: next_rdata = `CLR_ZERO;
    endcase
  end

  always @(posedge mclk)
  begin
    if (reset)
      regRdata <= `CLR_ZERO;
    else if (regRead)
      regRdata <= next_rdata;
    else
      regRdata <= `CLR_ZERO;
  end

endmodule // clr_responder

/* File: clr_defs.vh */
`ifndef CLR_DEFS_VH
`define CLR_DEFS_VH

// function set selectors, upper half of the request word
`define CLR_SET_STD 16'h0000
`define CLR_SET_EXT 16'h8000
`define CLR_SET_VND 16'h8086

// leaf numbers, lower half of the request word
`define CLR_LEAF_0 16'h0000
`define CLR_LEAF_1 16'h0001
`define CLR_LEAF_2 16'h0002
`define CLR_LEAF_3 16'h0003
`define CLR_LEAF_4 16'h0004
`define CLR_LEAF_5 16'h0005
`define CLR_LEAF_6 16'h0006

// fixed answers
`define CLR_STD_MAX_NOSERIAL 32'h0000_0001
`define CLR_STD_MAX_SERIAL 32'h0000_0003
`define CLR_EXT_MAX 32'h8000_0006
`define CLR_VND_MAX 32'h8086_0007
`define CLR_STD_FEATURES 32'h0080_813F
`define CLR_EXT_FEATURES 32'h0081_893F
`define CLR_TLB_DESC 32'h04FF_04FF
`define CLR_L1D_DESC 32'h4010_0120
`define CLR_L1C_DESC 32'h4008_0140
`define CLR_L2_DESC_SMALL 32'h0100_4180
`define CLR_L2_DESC_LARGE 32'h0200_4180
`define CLR_ZERO 32'h0000_0000

// field positions
`define CLR_FEAT_SERIAL_BIT 18
`define CLR_FEAT_FLOAT_CONDITIONAL_MOVE_FLAG_BIT 16
`define CLR_SIG_KEEP_MASK 32'h0000_3FFF

// register byte offsets
`define CLR_OFS_CTRL 6'h00
`define CLR_OFS_VEND_A 6'h04
`define CLR_OFS_VEND_B 6'h08
`define CLR_OFS_VEND_C 6'h0C
`define CLR_OFS_SIG 6'h10
`define CLR_OFS_MASK 6'h14
`define CLR_OFS_SERIAL0 6'h18
`define CLR_OFS_SERIAL1 6'h1C
`define CLR_OFS_SERIAL2 6'h20
`define CLR_OFS_SERIAL3 6'h24
`define CLR_OFS_MODEL0 6'h28
`define CLR_OFS_MODEL1 6'h2C
`define CLR_OFS_MODEL2 6'h30
`define CLR_OFS_STATUS 6'h34

// control register bits
`define CLR_CTRL_SERIAL_EN 0
`define CLR_CTRL_L2_LARGE 1
`define CLR_CTRL_ID_FLAG 2

// reset values
`define CLR_RST_CTRL 3'h0
`define CLR_RST_MASK 32'hFFFF_FFFF

`endif

/* File: clr_responder_properties.sv */
`timescale 1ns/1ps
module clr_responder_properties (
  // clock and reset
  input wire mclk,
  input wire reset,
  // request side
  input wire reqValid,
  input wire [31:0] reqFunction,
  input wire olderRetired,
  input wire reqBusy,
  // result side
  input wire respValid,
  input wire [31:0] resultEax,
  input wire [31:0] resultEbx,
  input wire [31:0] resultEcx,
  input wire [31:0] resultEdx
);
  // code of the request being answered; a wait never takes a new one
  reg [31:0] heldCode;
  wire taken = reqValid && !reqBusy;
  wire [127:0] allWords = {resultEax, resultEbx, resultEcx, resultEdx};
  always @(posedge mclk)
  begin
    if (reset)
      heldCode <= 32'h0000_0000;
    else if (taken)
      heldCode <= reqFunction;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_prompt_answer: assert property (taken && olderRetired |=> respValid && !reqBusy)
    else $error("no answer one cycle after request");
  chk_wait_older: assert property (taken && !olderRetired |=> reqBusy && !respValid)
    else $error("answer given before older work retired");
  chk_busy_hold: assert property (reqBusy && !olderRetired |=> reqBusy && !respValid)
    else $error("wait left early");
  chk_busy_release: assert property (reqBusy && olderRetired |=> respValid && !reqBusy)
    else $error("wait not released");
  chk_results_hold: assert property (!respValid |-> $stable(allWords))
    else $error("results changed without valid");
  chk_unsupported_zero: assert property (respValid && heldCode inside {32'h0000_0002, 32'h8000_0007}
    |-> allWords == 128'h0) else $error("unsupported code not zero");
  chk_ext_max: assert property (respValid && heldCode == 32'h8000_0000 |-> resultEax == 32'h8000_0006)
    else $error("extended maximum level wrong");
  chk_vnd_max: assert property (respValid && heldCode == 32'h8086_0000 |-> resultEax == 32'h8086_0007)
    else $error("vendor maximum level wrong");
  chk_std1_zero: assert property (respValid && heldCode == 32'h0000_0001 |-> !(resultEbx | resultEcx))
    else $error("standard leaf 1 not zero");
  chk_cache_desc: assert property (respValid && heldCode == 32'h8000_0005
    |-> {resultEbx, resultEcx, resultEdx} == {32'h04FF_04FF, 32'h4010_0120, 32'h4008_0140})
    else $error("level-one descriptors wrong");
  cover property (taken && !olderRetired);
  cover property (taken && olderRetired);
  cover property (respValid && heldCode == 32'h0000_0003);
endmodule // clr_responder_properties

bind clr_responder clr_responder_properties clr_responder_properties_inst (.mclk(mclk), .reset(reset),
  .reqValid(reqValid), .reqFunction(reqFunction), .olderRetired(olderRetired), .reqBusy(reqBusy),
  .respValid(respValid), .resultEax(resultEax), .resultEbx(resultEbx), .resultEcx(resultEcx),
  .resultEdx(resultEdx));

/* File: clr_retire_model.sv */
`timescale 1ns/1ps
module clr_retire_model (
  // clock and reset
  input wire mclk,
  input wire reset,
  // request watch and stall length
  input wire reqValid,
  input wire [3:0] lag,
  // retirement state
  output wire olderRetired
);
  // older work still draining holds the answer back
  reg [3:0] left;
  assign olderRetired = (left == 4'h0) && !(reqValid && lag != 4'h0);
  always @(posedge mclk)
  begin
    if (reset)
      left <= 4'h0;
    else if (left != 4'h0)
      left <= left - 4'h1;
    else if (reqValid)
      left <= lag;
  end
endmodule // clr_retire_model

/* File: clr_responder_tb.sv */
`timescale 1ns/1ps
`include "clr_defs.vh"
module clr_responder_tb;
  // arbitrary identity values
  localparam [31:0] VA = 32'h4141_4141, VB = 32'h4242_4242, VC = 32'h4343_4343;
  localparam [31:0] XB = 32'h5858_5842, XC = 32'h5858_5843, XD = 32'h5858_5844, XS = 32'h0000_0512;
  localparam [127:0] NP = 128'h3332_3130_2D43_4241_2D58_5858_2050_4F43;
  reg mclk = 1'b0;
  reg reset = 1'b1;
  reg [5:0] regAddr = 6'h00;
  reg [31:0] regWdata = 32'h0000_0000;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg reqValid = 1'b0;
  reg [31:0] reqFunction = 32'h0000_0000;
  reg [3:0] lag = 4'h0;
  wire olderRetired, reqBusy, respValid, idFlag;
  wire [31:0] regRdata, resultEax, resultEbx, resultEcx, resultEdx;
  integer mismatches = 0;
  integer samplesChecked = 0;
  integer cycles = 0;
  always #2.5 mclk = ~mclk;
  clr_responder #(.VEND_A_RESET(VA), .VEND_B_RESET(VB), .VEND_C_RESET(VC), .EXT_VEND_EBX(XB),
    .EXT_VEND_ECX(XC), .EXT_VEND_EDX(XD), .EXT_SIGNATURE(XS), .NAME_PREFIX(NP)) clr_responder_inst (.mclk(mclk),
    .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .reqValid(reqValid), .reqFunction(reqFunction), .olderRetired(olderRetired),
    .reqBusy(reqBusy), .respValid(respValid), .resultEax(resultEax), .resultEbx(resultEbx),
    .resultEcx(resultEcx), .resultEdx(resultEdx), .idFlag(idFlag));
  clr_retire_model clr_retire_model_inst (.mclk(mclk), .reset(reset), .reqValid(reqValid), .lag(lag),
    .olderRetired(olderRetired));
  task close_out;
  begin
    if (mismatches == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task check(input string nm, input [31:0] got, input [31:0] exp);
  begin
    samplesChecked = samplesChecked + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  task wr(input [5:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  end
  endtask
  task rd(input [5:0] a, input [31:0] e);
  begin
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    check("regRdata", regRdata, e);
  end
  endtask
  // one request; busy expected only while the stall model holds back
  task ask(input [31:0] fn, input [31:0] ea, input [31:0] eb, input [31:0] ec, input [31:0] ed);
    integer n;
  begin
    n = 0;
    @(posedge mclk);
    reqFunction <= fn;
    reqValid <= 1'b1;
    @(posedge mclk);
    reqValid <= 1'b0;
    #1;
    check("reqBusy", 32'(reqBusy), 32'(lag != 4'h0));
    while (respValid !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n = n + 1;
    end
    check("respValid", 32'(respValid), 32'h0000_0001);
    check("resultEax", resultEax, ea);
    check("resultEbx", resultEbx, eb);
    check("resultEcx", resultEcx, ec);
    check("resultEdx", resultEdx, ed);
  end
  endtask
  task t_reset_values;
  begin
    rd(`CLR_OFS_CTRL, 32'h0000_0000);
    rd(`CLR_OFS_VEND_C, VC);
    rd(`CLR_OFS_MASK, 32'hFFFF_FFFF);
    rd(6'h38, 32'h0000_0000);
  end
  endtask
  task t_std_leaves;
  begin
    ask(32'h0000_0000, 32'h0000_0001, VA, VC, VB);
    wr(`CLR_OFS_SIG, 32'hFFFF_FFFF);
    rd(`CLR_OFS_SIG, 32'h0000_3FFF);
    ask(32'h0000_0001, 32'h0000_3FFF, 0, 0, 32'h0080_813F);
    wr(`CLR_OFS_MASK, 32'hFFFF_FF0F);
    ask(32'h0000_0001, 32'h0000_3FFF, 0, 0, 32'h0080_810F);
    ask(32'h0000_0002, 0, 0, 0, 0);
  end
  endtask
  task t_serial;
  begin
    wr(`CLR_OFS_SERIAL0, 32'h3130_4641);
    wr(`CLR_OFS_SERIAL3, 32'h3938_3736);
    wr(`CLR_OFS_CTRL, 32'h0000_0001);
    wr(`CLR_OFS_VEND_B, 32'h4444_4444);
    ask(32'h0000_0000, 32'h0000_0003, VA, VC, 32'h4444_4444);
    ask(32'h0000_0003, 32'h3130_4641, 0, 0, 32'h3938_3736);
  end
  endtask
  task t_ext_leaves;
  begin
    wr(`CLR_OFS_MODEL0, 32'h3433_3231);
    wr(`CLR_OFS_MODEL2, 32'hFF31_3039);
    ask(32'h8000_0002, NP[31:0], NP[63:32], NP[95:64], NP[127:96]);
    ask(32'h8000_0003, 32'h3433_3231, 0, 32'h0031_3039, 0);
    ask(32'h8000_0004, 0, 0, 0, 0);
    ask(32'h8000_0000, 32'h8000_0006, XB, XC, XD);
    ask(32'h8000_0001, XS, 0, 0, 32'h0081_893F);
    ask(32'h8000_0005, 0, 32'h04FF_04FF, 32'h4010_0120, 32'h4008_0140);
    ask(32'h8000_0006, 0, 0, 32'h0100_4180, 0);
    wr(`CLR_OFS_CTRL, 32'h0000_0002);
    ask(32'h8000_0006, 0, 0, 32'h0200_4180, 0);
    ask(32'h0000_0003, 0, 0, 0, 0);
    ask(32'h8086_0000, 32'h8086_0007, XB, XC, XD);
    ask(32'h8000_0007, 0, 0, 0, 0);
    ask(32'h1234_0001, 0, 0, 0, 0);
  end
  endtask
  task t_wait_and_flag;
  begin
    lag <= 4'h3;
    ask(32'h8086_0000, 32'h8086_0007, XB, XC, XD);
    lag <= 4'h0;
    wr(`CLR_OFS_CTRL, 32'h0000_0004);
    #1;
    check("idFlag", 32'(idFlag), 32'h0000_0001);
  end
  endtask
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset_values;
    t_std_leaves;
    t_serial;
    t_ext_leaves;
    t_wait_and_flag;
    close_out;
  end
endmodule // clr_responder_tb
